// File: zero_current_detect_startup.sv
`timescale 1ns/100ps
`include "zcd_defs.svh"
// Functional notes
// - Switch command rise starts blanking, no pulse
// - After blanking, watch current sign while high
// - Negative current: crossing, delay, then pulse
// - Positive at blank end: pulse at once
// - Fault held low while supply rises
// - Rails build only above rising threshold
// - Supply dip halts build until recovered
// - Rails ready: release fault, follow command
// - Open slew pin reports a fault
module zero_current_detect_startup #(
   parameter int COUNT_W = `COUNT_W
) (
   // Clock, reset, enable
   input  wire logic                      mclk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      ce_i,
   // Switch command and current sign (1 = positive drain current)
   input  wire logic                      switch_cmd_i,
   input  wire logic                      current_positive_i,
   // Supply and rail comparators
   input  wire zcd_pkg::supply_sense_type sense_i,
   // Outputs
   output logic                           current_cross_pulse_o,
   output logic                           gate_on_o,
   output logic                           rail_enable_o,
   output logic                           fault_n_o
);
   localparam logic [COUNT_W-1:0] BLANK_N = COUNT_W'(`BLANK_CYCLES);
   localparam logic [COUNT_W-1:0] DELAY_N = COUNT_W'(`CROSSING_CYCLES);
   localparam logic [COUNT_W-1:0] PULSE_N = COUNT_W'(`PULSE_CYCLES);

   zcd_pkg::zc_state_type state;
   logic [COUNT_W-1:0]    count;
   logic                  cmd_prev;
   logic                  cmd_rise;
   logic                  ready;

   // Last cycle of a timed interval
   function automatic logic at_end(input logic [COUNT_W-1:0] c, input logic [COUNT_W-1:0] n);
      at_end = (c == n - COUNT_W'(1));
   endfunction

   // Start-up sequencer; its ready flag gates the switch, its fault output goes to the pin
   startup_seq u_startup (
      .mclk_i        (mclk_i),
      .rst_n_i       (rst_n_i),
      .ce_i          (ce_i),
      .sense_i       (sense_i),
      .rail_enable_o (rail_enable_o),
      .ready_o       (ready),
      .fault_n_o     (fault_n_o)
   );

   // History resets to the idle command level, so leaving reset with the command low never looks like a rise; a command already high counts as one
   assign cmd_rise = switch_cmd_i && !cmd_prev;

   // Command edge history
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cmd_prev <= 1'b0;
      end else if (ce_i) begin
         cmd_prev <= switch_cmd_i;
      end
   end

   // Gate follows the command only once start-up completes
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gate_on_o <= 1'b0;
      end else if (ce_i) begin
         gate_on_o <= ready && switch_cmd_i;
      end
   end

   // Detector sequencer; a falling command aborts everything except a running pulse,
   // which completes so the controller always sees the full width
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= zcd_pkg::ZC_IDLE;
         count <= '0;
      end else if (ce_i) begin
         case (state)
            zcd_pkg::ZC_IDLE: begin
               count <= '0;
               if (cmd_rise) begin
                  state <= zcd_pkg::ZC_BLANK;
               end
            end
            zcd_pkg::ZC_BLANK: begin
               count <= count + COUNT_W'(1);
               if (!switch_cmd_i) begin
                  state <= zcd_pkg::ZC_IDLE;
               end else if (at_end(count, BLANK_N)) begin
                  count <= '0;
                  if (current_positive_i) begin
                     state <= zcd_pkg::ZC_PULSE;
                  end else begin
                     state <= zcd_pkg::ZC_WAIT_CROSS;
                  end
               end
            end
            zcd_pkg::ZC_WAIT_CROSS: begin
               count <= '0;
               if (!switch_cmd_i) begin
                  state <= zcd_pkg::ZC_IDLE;
               end else if (current_positive_i) begin
                  state <= zcd_pkg::ZC_DELAY;
               end
            end
            zcd_pkg::ZC_DELAY: begin
               count <= count + COUNT_W'(1);
               if (!switch_cmd_i) begin
                  state <= zcd_pkg::ZC_IDLE;
               end else if (at_end(count, DELAY_N)) begin
                  count <= '0;
                  state <= zcd_pkg::ZC_PULSE;
               end
            end
            zcd_pkg::ZC_PULSE: begin
               count <= count + COUNT_W'(1);
               if (at_end(count, PULSE_N)) begin
                  count <= '0;
                  state <= switch_cmd_i ? zcd_pkg::ZC_DONE : zcd_pkg::ZC_IDLE;
               end
            end
            zcd_pkg::ZC_DONE: begin
               count <= '0;
               if (!switch_cmd_i) begin
                  state <= zcd_pkg::ZC_IDLE;
               end
            end
            default: begin
               state <= zcd_pkg::ZC_IDLE;
               count <= '0;
            end
         endcase
      end
   end

   // Registered pulse output, high only in the pulse state
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         current_cross_pulse_o <= 1'b0;
      end else if (ce_i) begin
         current_cross_pulse_o <= (state == zcd_pkg::ZC_PULSE);
      end
   end

   sequence blank_window_s;
      ce_i && state == zcd_pkg::ZC_BLANK;
   endsequence

   // Last blanking cycle with the command still high: the two detection paths fork here
   sequence blank_last_s;
      ce_i && state == zcd_pkg::ZC_BLANK && switch_cmd_i && at_end(count, BLANK_N);
   endsequence

   // Detector checks
   blank_no_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      blank_window_s |=> !current_cross_pulse_o)
      else $error("pulse during blanking");
   blank_enter_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && state == zcd_pkg::ZC_IDLE && cmd_rise) |=> state == zcd_pkg::ZC_BLANK)
      else $error("blanking not started on rising command");
   sign_watch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      blank_last_s ##0 !current_positive_i |=> state == zcd_pkg::ZC_WAIT_CROSS)
      else $error("negative current not watched");
   cross_delay_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && state == zcd_pkg::ZC_WAIT_CROSS && switch_cmd_i && current_positive_i)
      |=> !current_cross_pulse_o && state == zcd_pkg::ZC_DELAY)
      else $error("crossing pulse without delay");
   instant_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      blank_last_s ##0 current_positive_i |=> state == zcd_pkg::ZC_PULSE)
      else $error("positive current pulse not immediate");
   pulse_high_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && state == zcd_pkg::ZC_PULSE) |=> current_cross_pulse_o)
      else $error("pulse state without output");
   pulse_end_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && state == zcd_pkg::ZC_DONE) |=> !current_cross_pulse_o)
      else $error("second pulse in one command period");
   idle_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && state != zcd_pkg::ZC_PULSE) |=> !current_cross_pulse_o)
      else $error("output high outside the pulse state");
   // A falling command leaves every waiting state at once; only a running pulse finishes
   abort_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && !switch_cmd_i && (state == zcd_pkg::ZC_BLANK || state == zcd_pkg::ZC_WAIT_CROSS
      || state == zcd_pkg::ZC_DELAY)) |=> state == zcd_pkg::ZC_IDLE)
      else $error("falling command did not abort detection");
   gate_ready_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && !ready) |=> !gate_on_o)
      else $error("gate on before start-up done");

   // Clock enable low must leave the detector exactly where it was
   freeze_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !ce_i |=> $stable(state) && $stable(count) && $stable(current_cross_pulse_o))
      else $error("detector moved while the clock enable was low");

   // Width watch: counts the active cycles of the output so a stretched or cut pulse is caught;
   // it freezes with the clock enable just as the output does
   logic [COUNT_W-1:0] pulse_len;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pulse_len <= '0;
      end else if (ce_i) begin
         pulse_len <= current_cross_pulse_o ? pulse_len + COUNT_W'(1) : '0;
      end
   end

   width_end_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && current_cross_pulse_o && pulse_len == PULSE_N - COUNT_W'(1)) |=> !current_cross_pulse_o)
      else $error("pulse longer than its fixed width");
   // A pulse that drops must have run its full width
   width_full_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && !current_cross_pulse_o && pulse_len != '0) |-> pulse_len == PULSE_N)
      else $error("pulse shorter than its fixed width");
   pulse_cap_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      pulse_len <= PULSE_N)
      else $error("pulse width counter overran");
endmodule

// File: zcd_defs.svh
`ifndef CROSS_DETECT_DEFS_SVH
`define CROSS_DETECT_DEFS_SVH
// Timing figures in ns, clock period in ns
`define CLK_PERIOD_NS        4
`define BLANK_TIME_NS        100
`define CROSSING_DELAY_NS    40
`define PULSE_WIDTH_NS       60
// Cycle counts: blanking is a least time (round up), delay and width likewise
`define BLANK_CYCLES         ((`BLANK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CROSSING_CYCLES      ((`CROSSING_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_CYCLES         ((`PULSE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define COUNT_W              8
`endif

// File: zcd_pkg.sv
package zcd_pkg;
   typedef enum logic [2:0] {
      ZC_IDLE,
      ZC_BLANK,
      ZC_WAIT_CROSS,
      ZC_DELAY,
      ZC_PULSE,
      ZC_DONE
   } zc_state_type;

   typedef enum logic [1:0] {
      SU_SUPPLY_RISE,
      SU_RAIL_BUILD,
      SU_READY
   } su_state_type;

   // Analog comparator levels seen by the supervision logic
   typedef struct packed {
      logic supply_above_rise;
      logic supply_below_fall;
      logic internal_logic_rail_ok;
      logic negative_gate_rail_ok;
      logic slew_set_pin_open;
   } supply_sense_type;
endpackage

// File: startup_seq.sv
`timescale 1ns/100ps
`include "zcd_defs.svh"
module startup_seq (
   // Clock and reset
   input  wire logic                   mclk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   ce_i,
   // Sense inputs
   input  wire zcd_pkg::supply_sense_type sense_i,
   // Outputs
   output logic                        rail_enable_o,
   output logic                        ready_o,
   output logic                        fault_n_o
);
   zcd_pkg::su_state_type state;

   // Sequencer: lockout, rail build, ready
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= zcd_pkg::SU_SUPPLY_RISE;
      end else if (ce_i) begin
         case (state)
            zcd_pkg::SU_SUPPLY_RISE: begin
               if (sense_i.supply_above_rise) begin
                  state <= zcd_pkg::SU_RAIL_BUILD;
               end
            end
            zcd_pkg::SU_RAIL_BUILD: begin
               if (sense_i.supply_below_fall) begin
                  state <= zcd_pkg::SU_SUPPLY_RISE;
               end else if (sense_i.internal_logic_rail_ok && sense_i.negative_gate_rail_ok) begin
                  state <= zcd_pkg::SU_READY;
               end
            end
            zcd_pkg::SU_READY: begin
               if (sense_i.supply_below_fall) begin
                  state <= zcd_pkg::SU_SUPPLY_RISE;
               end
            end
            default: state <= zcd_pkg::SU_SUPPLY_RISE;
         endcase
      end
   end

   // Fault output registered; low until ready and on an open slew pin
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_n_o     <= 1'b0;
         rail_enable_o <= 1'b0;
         ready_o       <= 1'b0;
      end else if (ce_i) begin
         rail_enable_o <= (state != zcd_pkg::SU_SUPPLY_RISE);
         ready_o       <= (state == zcd_pkg::SU_READY);
         fault_n_o     <= (state == zcd_pkg::SU_READY) && !sense_i.slew_set_pin_open;
      end
   end

   // Fault stays low while the supply is still rising
   supply_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && state == zcd_pkg::SU_SUPPLY_RISE) |=> !fault_n_o)
      else $error("fault released during supply rise");
   rail_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && state == zcd_pkg::SU_SUPPLY_RISE) |=> !rail_enable_o)
      else $error("rails enabled under lockout");
   build_halt_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && state == zcd_pkg::SU_RAIL_BUILD && sense_i.supply_below_fall)
      |=> state == zcd_pkg::SU_SUPPLY_RISE)
      else $error("rail build not halted");
   open_pin_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && sense_i.slew_set_pin_open) |=> !fault_n_o)
      else $error("open slew pin not reported");
   fault_release_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (ce_i && state == zcd_pkg::SU_READY && !sense_i.slew_set_pin_open) |=> fault_n_o)
      else $error("fault not released when ready");
endmodule

// File: ctl_model.sv
`timescale 1ns/100ps
module ctl_model (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   // Bench request and device status
   input  wire logic run_i,
   input  wire logic fault_n_i,
   // Switch command to the device
   output logic      switch_cmd_o
);
   // Switch only after power-up and stop one clock after a fault, so after a supply fault the command outlasts the device's ready by one cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         switch_cmd_o <= 1'b0;
      else
         switch_cmd_o <= run_i && fault_n_i;
   end
endmodule

// File: zero_current_detect_startup_test.sv
`timescale 1ns/100ps
`include "zcd_defs.svh"
`define CHK(nm, ex, ac) begin tests_run++; if ((ac) !== (ex)) begin err_total++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, ac); end end
module zero_current_detect_startup_test;
   logic                      mclk_i  = 1'b0;
   logic                      rst_n_i = 1'b0;
   logic                      run     = 1'b0;
   logic                      cur_pos = 1'b0;
   logic                      ce      = 1'b1;
   zcd_pkg::supply_sense_type sense   = 5'h08;
   logic                      pulse;
   logic                      gate_on;
   logic                      rail_en;
   logic                      fault_n;
   logic                      cmd;
   int                        err_total = 0;
   int                        tests_run = 0;
   int                        n;
   // Clock at 250 MHz
   always #2 mclk_i = ~mclk_i;
   zero_current_detect_startup dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce),
      .switch_cmd_i(cmd), .current_positive_i(cur_pos), .sense_i(sense),
      .current_cross_pulse_o(pulse), .gate_on_o(gate_on), .rail_enable_o(rail_en), .fault_n_o(fault_n));
   ctl_model ctl_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .run_i(run), .fault_n_i(fault_n), .switch_cmd_o(cmd));
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Sample just after the edge so the design's updates have landed
   task automatic tick(input int c);
      repeat (c) @(posedge mclk_i);
      #1;
   endtask
   // Bounded wait for the pulse; a hang ends the run
   task automatic wait_pulse(input int lim, output int k);
      k = 0;
      while (pulse !== 1'b1) begin
         tick(1);
         k++;
         if (k > lim) begin
            err_total++;
            $display("mismatch pulse_wait expected 1 seen 0");
            summarize();
         end
      end
   endtask
   task automatic width(output int w);
      w = 0;
      while (pulse === 1'b1 && w < 100) begin
         tick(1);
         w++;
      end
   endtask
   task automatic count_hi(input int c, output int h);
      h = 0;
      repeat (c) begin
         tick(1);
         if (pulse !== 1'b0)
            h++;
      end
   endtask
   task automatic t_startup();
      tick(5);
      `CHK("fault_n", 1'b0, fault_n)
      `CHK("rail_en", 1'b0, rail_en)
      @(posedge mclk_i) sense <= 5'h10;
      tick(3);
      `CHK("rail_en", 1'b1, rail_en)
      `CHK("fault_n", 1'b0, fault_n)
      @(posedge mclk_i) sense <= 5'h0C;
      tick(3);
      `CHK("rail_en", 1'b0, rail_en)
      `CHK("fault_n", 1'b0, fault_n)
      @(posedge mclk_i) sense <= 5'h14;
      tick(3);
      `CHK("rail_en", 1'b1, rail_en)
      `CHK("fault_n", 1'b0, fault_n)
      @(posedge mclk_i) sense <= 5'h16;
      tick(3);
      `CHK("fault_n", 1'b1, fault_n)
      $display("test startup done");
   endtask
   // Current already positive when blanking ends
   task automatic t_positive();
      @(posedge mclk_i) begin
         cur_pos <= 1'b1;
         run <= 1'b1;
      end
      tick(1);
      wait_pulse(60, n);
      `CHK("pos_delay", 1'b1, n >= `BLANK_CYCLES + 2 && n <= `BLANK_CYCLES + 4)
      `CHK("gate_on", 1'b1, gate_on)
      width(n);
      `CHK("pos_width", `PULSE_CYCLES, n)
      count_hi(40, n);
      `CHK("extra_pulse", 0, n)
      @(posedge mclk_i) run <= 1'b0;
      tick(3);
      `CHK("gate_off", 1'b0, gate_on)
      $display("test positive done");
   endtask
   // Negative current: wait for the crossing, then the delay
   task automatic t_negative();
      @(posedge mclk_i) begin
         cur_pos <= 1'b0;
         run <= 1'b1;
      end
      count_hi(60, n);
      `CHK("neg_early", 0, n)
      @(posedge mclk_i) cur_pos <= 1'b1;
      wait_pulse(40, n);
      `CHK("neg_delay", 1'b1, n >= `CROSSING_CYCLES + 1 && n <= `CROSSING_CYCLES + 4)
      width(n);
      `CHK("neg_width", `PULSE_CYCLES, n)
      count_hi(30, n);
      `CHK("extra_pulse", 0, n)
      @(posedge mclk_i) run <= 1'b0;
      tick(3);
      $display("test negative done");
   endtask
   // Command dropped inside blanking yields no pulse
   task automatic t_abort();
      @(posedge mclk_i) run <= 1'b1;
      tick(10);
      @(posedge mclk_i) run <= 1'b0;
      count_hi(60, n);
      `CHK("abort_pulse", 0, n)
      $display("test abort done");
   endtask
   // Open slew pin gives a fault that clears without latching
   task automatic t_open_pin();
      @(posedge mclk_i) sense <= 5'h17;
      tick(3);
      `CHK("fault_n", 1'b0, fault_n)
      @(posedge mclk_i) sense <= 5'h16;
      tick(3);
      `CHK("fault_n", 1'b1, fault_n)
      $display("test open_pin done");
   endtask
   // Supply dip while waiting for a crossing: lockout returns, the command is withheld, nothing fires
   task automatic t_dip();
      @(posedge mclk_i) begin
         cur_pos <= 1'b0;
         run     <= 1'b1;
      end
      tick(35);
      @(posedge mclk_i) sense <= 5'h0E;
      tick(4);
      `CHK("dip_fault", 1'b0, fault_n)
      `CHK("dip_rail", 1'b0, rail_en)
      `CHK("dip_gate", 1'b0, gate_on)
      @(posedge mclk_i) cur_pos <= 1'b1;
      count_hi(40, n);
      `CHK("dip_pulse", 0, n)
      @(posedge mclk_i) begin
         run   <= 1'b0;
         sense <= 5'h16;
      end
      tick(4);
      `CHK("dip_back", 1'b1, fault_n)
      $display("test dip done");
   endtask
   // Clock enable low in mid-pulse holds the pulse high; it resumes on release
   task automatic t_freeze();
      @(posedge mclk_i) run <= 1'b1;
      tick(1);
      wait_pulse(60, n);
      @(posedge mclk_i) ce <= 1'b0;
      repeat (20) @(posedge mclk_i);
      #1;
      `CHK("frz_pulse", 1'b1, pulse)
      @(posedge mclk_i) ce <= 1'b1;
      width(n);
      // Two active pulse edges fall before the freeze; the count also takes the clearing edge
      `CHK("frz_width", `PULSE_CYCLES - 1, n)
      @(posedge mclk_i) run <= 1'b0;
      tick(3);
      $display("test freeze done");
   endtask
   initial begin
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_startup();
      t_positive();
      t_negative();
      t_abort();
      t_open_pin();
      t_dip();
      t_freeze();
      summarize();
   end
endmodule
